// *** src/dppc_defs.svh ***
/*
  Constants for the dual port positioning control block: register byte
  offsets, field positions, reset values, function codes, address limits
  and timing counts.
  Assumes inclusion by bare name from the top module.
*/
`ifndef DPPC_DEFS_SVH
`define DPPC_DEFS_SVH

// Register byte offsets on the Avalon-MM slave
`define DPPC_CTRL_OFS        5'h00
`define DPPC_DCYL_OFS        5'h04
`define DPPC_SECTRK_OFS      5'h08
`define DPPC_CCYL_OFS        5'h0c
`define DPPC_STATUS_OFS      5'h10
`define DPPC_FORMAT_OFS      5'h14

// Control register fields
`define DPPC_CTRL_GO_BIT     0
`define DPPC_CTRL_FN_LSB     1
`define DPPC_CTRL_FN_MSB     5

// Sector/track register fields
`define DPPC_SECT_LSB        0
`define DPPC_SECT_MSB        4
`define DPPC_TRK_LSB         8
`define DPPC_TRK_MSB         12

// Status register fields
`define DPPC_ST_GO           0
`define DPPC_ST_ATTN         1
`define DPPC_ST_BAD          2
`define DPPC_ST_OFS_HOLD     3
`define DPPC_ST_OFS_FLAG     4
`define DPPC_ST_A_OWNED      5
`define DPPC_ST_B_OWNED      6
`define DPPC_ST_A_LATCH      7
`define DPPC_ST_B_LATCH      8
`define DPPC_ST_READY        9

// Reset value of the whole state record
`define DPPC_STATE_RESET     '0

// Function codes
`define DPPC_FN_SEEK         5'h02
`define DPPC_FN_RELEASE      5'h05
`define DPPC_FN_OFFSET       5'h06
`define DPPC_FN_RTC          5'h07
`define DPPC_FN_SEARCH       5'h0c
`define DPPC_FN_WRITE        5'h18
`define DPPC_FN_READ         5'h1c

// Address limits
`define DPPC_MAX_CYL         9'h19a
`define DPPC_MAX_TRK         5'h12
`define DPPC_MAX_SECT18      5'h13
`define DPPC_MAX_SECT16      5'h15

// Timing
`define DPPC_HOLD_TIME_MS    32'h3e8
`define DPPC_CLK_KHZ         32'hc350

`endif

// *** src/dppc_pkg.sv ***
/*
  Types of the dual port positioning control block: pin groups, status
  groups, drive outputs, positioning states and the state record.
  Assumes the constants header is on the include path.
*/
package dppc_pkg;

  typedef enum logic [2:0] {
    PS_IDLE      = 3'b000,
    PS_DECODE    = 3'b001,
    PS_RTC_MOVE  = 3'b010,
    PS_RTC_WAIT  = 3'b011,
    PS_SEEK_MOVE = 3'b100,
    PS_SEEK_WAIT = 3'b101,
    PS_OFS_MOVE  = 3'b110,
    PS_OFS_WAIT  = 3'b111
  } dppc_pos_state_t;

  typedef struct packed {
    logic       demand;
    logic       wr;
    logic       ctrl_sel;
    logic       attn_clr;
    logic       hs_clk;
    logic [2:0] unit;
  } dppc_port_pins_t;

  typedef struct packed {
    logic owned;
    logic request_latch;
    logic release_flag;
  } dppc_port_stat_t;

  typedef struct packed {
    logic position_strobe;
    logic centering_pulse;
    logic move_request;
    logic move_phase_one;
    logic move_phase_two;
    logic move_phase_three;
    logic offset_flag;
    logic offset_hold;
    logic cylinder_load;
    logic cylinder_advance;
  } dppc_drive_out_t;

  typedef struct packed {
    logic [21:0]       s1;
    logic [21:0]       s2;
    logic [21:0]       s3;
    logic [21:0]       f;
    logic [1:0][1:0]   hs_phase;
    logic [1:0]        blocked;
    logic [1:0]        owned;
    logic [1:0]        latch;
    logic [1:0]        rel;
    logic [1:0]        rel_cnt;
    logic [25:0]       hold_cnt;
    dppc_pos_state_t   st;
    logic              go;
    logic [4:0]        func;
    logic              positioning;
    logic [1:0]        mc;
    logic [8:0]        dcyl;
    logic [8:0]        ccyl;
    logic [4:0]        track;
    logic [4:0]        sector;
    logic              format16;
    logic              attention;
    logic              bad;
    logic              ready;
    logic              ack;
    logic [31:0]       rdata;
    dppc_drive_out_t   o;
  } dppc_state_t;

endpackage

// *** src/dppc_top.sv ***
/*
  Dual port positioning control: drive ownership arbitration between two
  controllers and sequencing of seek, implied seek, offset and return to
  centerline moves, with registers on an Avalon-MM slave.
  Assumes ref_clk at 50 MHz; all pins from the controllers and the drive
  are asynchronous, and all but track_end_strobe are filtered here.
*/
// Behaviour
// - Unowned drive goes to addressing demanding port
// - Read-only ownership ends when demand drops
// - Write or control access sets request latch
// - Latch set while other owns; handover on release
// - Selected only when unit lines match switches
// - Phase one grants if other port not owner
// - Phase-one grant blocked for rest of handshake
// - Phase two write/control raises persistent request
// - Phase three attention clear raises request
// - Release: flag, clear latch, drop after two
// - Demand over one second idle forces release
// - Earliest handshake clock edge wins simultaneous demand
// - Seek on equal cylinders: done, attention
// - Out of range address flags bad, ends command
// - Seek in offset centres first, then continues
// - Move counter gives three phases, then idles
// - Seek strobe phase two; ready loads current cylinder
// - Implied seek completion keeps go, no attention
// - Spiral wrap advances desired cylinder by one
// - Offset sets mode, strobes, ends on done
// - Offset hold persists until centred
// - Implied centering drops flag at phase three
`include "dppc_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module dppc_top #(
  parameter int unsigned HOLD_CYCLES = `DPPC_HOLD_TIME_MS * `DPPC_CLK_KHZ
) (
  // Clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      resetn,
  // Avalon-MM slave
  input  wire logic [4:0]                avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  output logic      [31:0]               avs_readdata,
  output logic                           avs_waitrequest,
  // Controller pins
  input  wire dppc_pkg::dppc_port_pins_t port_a_pins,
  input  wire dppc_pkg::dppc_port_pins_t port_b_pins,
  input  wire logic [2:0]                unit_number_switches,
  // Drive pins
  input  wire logic                      selected_sector_clock,
  input  wire logic                      heads_settled,
  input  wire logic                      offset_done,
  input  wire logic                      track_end_strobe,
  // Ownership status
  output dppc_pkg::dppc_port_stat_t      port_a_stat,
  output dppc_pkg::dppc_port_stat_t      port_b_stat,
  // Drive control
  output dppc_pkg::dppc_drive_out_t      drive_out,
  output logic                           bad_address,
  output logic                           cylinder_ready
);
  import dppc_pkg::*;

  localparam logic [25:0] HOLD_LAST = 26'(HOLD_CYCLES - 32'h1);

  dppc_state_t          r;
  dppc_state_t          n;
  logic [21:0]          rise;
  dppc_port_pins_t [1:0] pins;
  logic [1:0]           dsel;
  logic [1:0]           hs_rise;
  logic                 sect_rise;
  logic                 settled_rise;
  logic                 ofsdone_rise;
  logic                 wr_take;
  logic                 release_now;
  logic                 is_xfer;
  logic                 bad_now;
  logic                 mreq;
  logic [4:0]           sect_max;

  always_comb begin
    n = r;
    release_now = 1'b0;
    // Three-stage filter; a change counts once stages two and three agree
    n.s1 = {unit_number_switches, selected_sector_clock, heads_settled,
            offset_done, port_b_pins, port_a_pins};
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.f = (r.s2 & r.s3) | (r.f & (r.s2 | r.s3));
    rise = n.f & ~r.f;
    pins = r.f[15:0];
    sect_rise = rise[18];
    settled_rise = rise[17];
    ofsdone_rise = rise[16];
    hs_rise = {rise[11], rise[3]};
    n.o.position_strobe = 1'b0;
    n.o.centering_pulse = 1'b0;
    n.o.cylinder_load = 1'b0;
    n.o.cylinder_advance = 1'b0;

    // Avalon slave: one wait state, read data loaded with the answer
    n.ack = (avs_read | avs_write) & ~r.ack;
    wr_take = avs_write & r.ack;
    if (avs_read && !r.ack) begin
      n.rdata = 32'h0;
      case (avs_address)
        `DPPC_CTRL_OFS: begin
          n.rdata[`DPPC_CTRL_GO_BIT] = r.go;
          n.rdata[`DPPC_CTRL_FN_MSB:`DPPC_CTRL_FN_LSB] = r.func;
        end
        `DPPC_DCYL_OFS: n.rdata[8:0] = r.dcyl;
        `DPPC_SECTRK_OFS: begin
          n.rdata[`DPPC_SECT_MSB:`DPPC_SECT_LSB] = r.sector;
          n.rdata[`DPPC_TRK_MSB:`DPPC_TRK_LSB] = r.track;
        end
        `DPPC_CCYL_OFS: n.rdata[8:0] = r.ccyl;
        `DPPC_STATUS_OFS: begin
          n.rdata[`DPPC_ST_GO] = r.go;
          n.rdata[`DPPC_ST_ATTN] = r.attention;
          n.rdata[`DPPC_ST_BAD] = r.bad;
          n.rdata[`DPPC_ST_OFS_HOLD] = r.o.offset_hold;
          n.rdata[`DPPC_ST_OFS_FLAG] = r.o.offset_flag;
          n.rdata[`DPPC_ST_A_OWNED] = r.owned[0];
          n.rdata[`DPPC_ST_B_OWNED] = r.owned[1];
          n.rdata[`DPPC_ST_A_LATCH] = r.latch[0];
          n.rdata[`DPPC_ST_B_LATCH] = r.latch[1];
          n.rdata[`DPPC_ST_READY] = r.ready;
        end
        `DPPC_FORMAT_OFS: n.rdata[0] = r.format16;
        default: n.rdata = 32'h0;
      endcase
    end
    if (wr_take) begin
      case (avs_address)
        `DPPC_CTRL_OFS: begin
          if (!r.go) begin
            n.func = avs_writedata[`DPPC_CTRL_FN_MSB:`DPPC_CTRL_FN_LSB];
            if (avs_writedata[`DPPC_CTRL_GO_BIT]) begin
              n.go = 1'b1;
              n.st = PS_DECODE;
            end
          end else if (r.st == PS_IDLE &&
                       !avs_writedata[`DPPC_CTRL_GO_BIT]) begin
            n.go = 1'b0;
          end
        end
        `DPPC_DCYL_OFS: if (!r.go) n.dcyl = avs_writedata[8:0];
        `DPPC_SECTRK_OFS: begin
          if (!r.go) begin
            n.sector = avs_writedata[`DPPC_SECT_MSB:`DPPC_SECT_LSB];
            n.track = avs_writedata[`DPPC_TRK_MSB:`DPPC_TRK_LSB];
          end
        end
        `DPPC_STATUS_OFS: begin
          if (avs_writedata[`DPPC_ST_ATTN]) n.attention = 1'b0;
          if (avs_writedata[`DPPC_ST_BAD]) n.bad = 1'b0;
        end
        `DPPC_FORMAT_OFS: n.format16 = avs_writedata[0];
        default: ;
      endcase
    end

    // Port arbitration; port A is looked at first, so a same-cycle tie
    // (impossible with opposed clocks) falls to A
    for (int p = 0; p < 2; p++) begin
      dsel[p] = pins[p].demand && (pins[p].unit == r.f[21:19]);
      if (!dsel[p]) begin
        n.hs_phase[p] = 2'h0;
        n.blocked[p] = 1'b0;
        if (r.owned[p] && !r.latch[p] && !r.rel[p])
          n.owned[p] = 1'b0;
      end else if (hs_rise[p]) begin
        case (r.hs_phase[p])
          2'h0: begin
            n.hs_phase[p] = 2'h1;
            if (!n.owned[1-p] && !r.blocked[p])
              n.owned[p] = 1'b1;
            n.blocked[p] = 1'b1;
          end
          2'h1: begin
            n.hs_phase[p] = 2'h2;
            if (pins[p].wr || pins[p].ctrl_sel)
              n.latch[p] = 1'b1;
          end
          2'h2: begin
            n.hs_phase[p] = 2'h3;
            if (pins[p].attn_clr) begin
              n.latch[p] = 1'b1;
              n.attention = 1'b0;
            end
          end
          default: n.hs_phase[p] = 2'h3;
        endcase
      end
      // Pending request takes the drive once the other side lets go
      if (hs_rise[p] && r.latch[p] && !r.owned[p] && !n.owned[1-p])
        n.owned[p] = 1'b1;
      if (r.rel[p] && hs_rise[p]) begin
        if (r.rel_cnt[p]) begin
          n.owned[p] = 1'b0;
          n.rel[p] = 1'b0;
          n.rel_cnt[p] = 1'b0;
          if (r.latch[1-p]) n.attention = 1'b1;
        end else begin
          n.rel_cnt[p] = 1'b1;
        end
      end
    end

    // Hold timer: idle demand or latch over one second releases owner
    if ((r.owned == 2'b00) || r.go ||
        (dsel == 2'b00 && (r.latch & r.owned) == 2'b00)) begin
      n.hold_cnt = 26'h0;
    end else if (r.hold_cnt == HOLD_LAST) begin
      n.hold_cnt = 26'h0;
      release_now = 1'b1;
    end else begin
      n.hold_cnt = r.hold_cnt + 26'h1;
    end

    // Positioning sequencer
    is_xfer = (r.func == `DPPC_FN_SEARCH) || (r.func == `DPPC_FN_READ) ||
              (r.func == `DPPC_FN_WRITE);
    sect_max = r.format16 ? `DPPC_MAX_SECT16 : `DPPC_MAX_SECT18;
    bad_now = (r.dcyl > `DPPC_MAX_CYL) || (r.track > `DPPC_MAX_TRK) ||
              (r.sector > sect_max);
    case (r.st)
      PS_IDLE: begin
        if (r.go && is_xfer && r.dcyl != r.ccyl)
          n.st = PS_DECODE;
      end
      PS_DECODE: begin
        case (r.func)
          `DPPC_FN_SEEK, `DPPC_FN_SEARCH, `DPPC_FN_READ,
          `DPPC_FN_WRITE: begin
            if (bad_now) begin
              n.bad = 1'b1;
              n.go = 1'b0;
              n.attention = 1'b1;
              n.st = PS_IDLE;
            end else if (r.o.offset_hold && (r.func == `DPPC_FN_SEEK ||
                                             r.func == `DPPC_FN_WRITE)) begin
              n.positioning = 1'b0;
              n.st = PS_RTC_MOVE;
            end else if (r.dcyl == r.ccyl) begin
              n.st = PS_IDLE;
              if (r.func == `DPPC_FN_SEEK) begin
                n.go = 1'b0;
                n.attention = 1'b1;
              end
            end else begin
              n.positioning = (r.func == `DPPC_FN_SEEK);
              n.st = PS_SEEK_MOVE;
            end
          end
          `DPPC_FN_OFFSET: begin
            n.o.offset_flag = 1'b1;
            n.o.offset_hold = 1'b1;
            n.positioning = 1'b1;
            n.st = PS_OFS_MOVE;
          end
          `DPPC_FN_RTC: begin
            n.positioning = 1'b1;
            n.st = PS_RTC_MOVE;
          end
          `DPPC_FN_RELEASE: begin
            release_now = 1'b1;
            n.go = 1'b0;
            n.st = PS_IDLE;
          end
          default: begin
            n.go = 1'b0;
            n.st = PS_IDLE;
          end
        endcase
      end
      PS_RTC_MOVE, PS_SEEK_MOVE, PS_OFS_MOVE: begin
        if (sect_rise && r.mc == 2'h3)
          n.st = dppc_pos_state_t'({r.st[2:1], 1'b1});
      end
      PS_RTC_WAIT: begin
        if (ofsdone_rise) begin
          n.o.offset_hold = 1'b0;
          // Commanded centering keeps the flag until the drive is centred
          n.o.offset_flag = 1'b0;
          if (r.positioning) begin
            n.go = 1'b0;
            n.attention = 1'b1;
            n.st = PS_IDLE;
          end else begin
            n.st = PS_DECODE;
          end
        end
      end
      PS_SEEK_WAIT: begin
        if (settled_rise) begin
          n.ccyl = r.dcyl;
          n.o.cylinder_load = 1'b1;
          n.st = PS_IDLE;
          if (r.positioning) begin
            n.go = 1'b0;
            n.attention = 1'b1;
          end
        end
      end
      PS_OFS_WAIT: begin
        if (ofsdone_rise) begin
          n.go = 1'b0;
          n.attention = 1'b1;
          n.st = PS_IDLE;
        end
      end
      default: n.st = PS_IDLE;
    endcase

    // Move counter; implied centering lets the request fall early so it
    // has settled low before the seek raises it again
    mreq = (r.st == PS_SEEK_MOVE) || (r.st == PS_OFS_MOVE) ||
           (r.st == PS_RTC_MOVE && (r.positioning || r.o.offset_flag));
    if (sect_rise) begin
      if (r.mc != 2'h0) begin
        n.mc = r.mc + 2'h1;
      end else if (mreq) begin
        n.mc = 2'h1;
      end
      if (r.mc == 2'h0 && mreq && r.st == PS_RTC_MOVE)
        n.o.centering_pulse = 1'b1;
      if (r.mc == 2'h1 &&
          (r.st == PS_SEEK_MOVE || r.st == PS_OFS_MOVE))
        n.o.position_strobe = 1'b1;
      if (r.mc == 2'h2 && r.st == PS_RTC_MOVE && !r.positioning)
        n.o.offset_flag = 1'b0;
    end
    n.o.move_request = mreq;
    n.o.move_phase_one = (n.mc == 2'h1);
    n.o.move_phase_two = (n.mc == 2'h2);
    n.o.move_phase_three = (n.mc == 2'h3);

    // Spiral wrap to the next cylinder
    if (track_end_strobe && r.go && is_xfer && r.st == PS_IDLE) begin
      n.dcyl = r.dcyl + 9'h1;
      n.o.cylinder_advance = 1'b1;
    end

    if (release_now) begin
      for (int p = 0; p < 2; p++) begin
        if (r.owned[p] && !r.rel[p]) begin
          n.rel[p] = 1'b1;
          n.latch[p] = 1'b0;
          n.rel_cnt[p] = 1'b0;
        end
      end
    end
    n.ready = (n.dcyl == n.ccyl) && (n.st == PS_IDLE);
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      r <= `DPPC_STATE_RESET;
    end else begin
      r <= n;
    end
  end

  assign avs_readdata = r.rdata;
  assign avs_waitrequest = (avs_read | avs_write) & ~r.ack;
  assign port_a_stat = {r.owned[0], r.latch[0], r.rel[0]};
  assign port_b_stat = {r.owned[1], r.latch[1], r.rel[1]};
  assign drive_out = r.o;
  assign bad_address = r.bad;
  assign cylinder_ready = r.ready;

endmodule

`default_nettype wire

// *** testbench/dppc_top_asserts.sv ***
/*
  Port checker for the dual port positioning control block.
  Assumes one clock domain and binding onto every dppc_top.
*/
`timescale 1ns/100ps
`default_nettype none
module dppc_chk (
  // Clock and reset
  input wire logic                      ref_clk,
  input wire logic                      resetn,
  // Watched outputs
  input wire dppc_pkg::dppc_port_stat_t port_a_stat,
  input wire dppc_pkg::dppc_port_stat_t port_b_stat,
  input wire dppc_pkg::dppc_drive_out_t drive_out,
  input wire logic                      bad_address
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  property p_phase_order;
    $rose(drive_out.move_phase_two) |-> $fell(drive_out.move_phase_one);
  endproperty
  a_phase_order: assert property (p_phase_order)
    else $error("phase two did not follow phase one");
  property p_phase_onehot;
    $onehot0({drive_out.move_phase_one, drive_out.move_phase_two,
              drive_out.move_phase_three});
  endproperty
  a_phase_onehot: assert property (p_phase_onehot)
    else $error("move phases overlap");
  property p_strobe_phase;
    drive_out.position_strobe |-> drive_out.move_phase_two;
  endproperty
  a_strobe_phase: assert property (p_strobe_phase)
    else $error("position strobe outside phase two");
  property p_center_phase;
    drive_out.centering_pulse |-> drive_out.move_phase_one;
  endproperty
  a_center_phase: assert property (p_center_phase)
    else $error("centering pulse outside phase one");
  property p_one_owner;
    !(port_a_stat.owned && port_b_stat.owned);
  endproperty
  a_one_owner: assert property (p_one_owner)
    else $error("both ports own the drive");
  property p_handover;
    $rose(port_b_stat.owned) |-> !$past(port_a_stat.owned);
  endproperty
  a_handover: assert property (p_handover)
    else $error("port b granted while a owned");
  property p_release;
    $rose(port_a_stat.release_flag) |-> ##[0:2] !port_a_stat.request_latch;
  endproperty
  a_release: assert property (p_release)
    else $error("release left request latch set");
  property p_bad_nomove;
    $rose(bad_address) |-> !drive_out.move_request [*4];
  endproperty
  a_bad_nomove: assert property (p_bad_nomove)
    else $error("move started on bad address");
  property p_hold_last;
    $fell(drive_out.offset_hold) |-> !drive_out.offset_flag;
  endproperty
  a_hold_last: assert property (p_hold_last)
    else $error("offset hold dropped before offset flag");
endmodule

bind dppc_top dppc_chk i_dppc_chk (
  .ref_clk(ref_clk), .resetn(resetn), .port_a_stat(port_a_stat),
  .port_b_stat(port_b_stat), .drive_out(drive_out),
  .bad_address(bad_address));
`default_nettype wire

// *** testbench/dppc_drive_model.sv ***
/*
  Drive mechanics model: free-running sector clock, seek and offset
  answers after a short or a long settle time.
  Assumes strobes and pulses last one ref_clk cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module dppc_drive_model (
  // Clock and pace
  input  wire logic                      ref_clk,
  input  wire logic                      slow,
  // Drive control from the block
  input  wire dppc_pkg::dppc_drive_out_t drive_out,
  // Drive answers
  output logic                           selected_sector_clock = 1'b0,
  output logic                           heads_settled = 1'b0,
  output logic                           offset_done = 1'b0
);
  logic [3:0] sc = '0;
  logic [5:0] cnt = '0;
  logic       busy = 1'b0;
  logic       ofs = 1'b0;
  always @(posedge ref_clk) begin
    sc <= (sc == 4'h9) ? 4'h0 : sc + 4'h1;
    selected_sector_clock <= (sc < 4'h5);
    // Answer kind fixed at the strobe, as the mechanism would
    if (drive_out.position_strobe || drive_out.centering_pulse) begin
      busy <= 1'b1;
      // Both delays outlast the remaining move phases; an answer that
      // came before the block waits for it would be missed
      cnt <= slow ? 6'h28 : 6'h20;
      ofs <= drive_out.centering_pulse || drive_out.offset_flag;
    end else if (busy) begin
      cnt <= cnt - 6'h01;
      if (cnt == 6'h00) begin
        heads_settled <= !ofs;
        offset_done <= ofs;
      end
      // Ready held eight cycles, long enough to pass the input filter
      if (cnt == 6'h38) begin
        heads_settled <= 1'b0;
        offset_done <= 1'b0;
        busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
/*
  Self-checking bench: Avalon register access, two controller ports and
  the drive model. Assumes the 200-cycle hold parameter.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import dppc_pkg::*;
  logic ref_clk = 1'b0, resetn = 1'b0, avs_read, avs_write, waitreq;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic dem_a, wr_a, dem_b, wr_b, slow, tes, bad, crdy, sclk, hset, odone;
  logic cs_a;
  logic [2:0] unit_a;
  logic [3:0] hs = '0;
  logic [9:0] mon;
  dppc_port_pins_t pa, pb;
  dppc_port_stat_t sa, sb;
  dppc_drive_out_t dout;
  int mismatches = 0, tests_run = 0, cyc = 0, i;
  logic [8:0] tdc [5] = '{9'h19b, 9'h0, 9'h0, 9'h0, 9'h0};
  logic [12:0] tst [5] = '{13'h0, 13'h1300, 13'h14, 13'h16, 13'h1215};
  logic [1:0] tfx [5] = '{2'b01, 2'b01, 2'b01, 2'b11, 2'b10};

  always #10 ref_clk = ~ref_clk;
  // Handshake clocks half a period apart
  always @(posedge ref_clk) hs <= hs + 4'h1;
  assign pa = {dem_a, wr_a, cs_a, cs_a, hs[3], unit_a};
  assign pb = {dem_b, wr_b, 2'b00, ~hs[3], unit_a};
  assign mon = {bad, crdy, dout.offset_flag, dout.offset_hold,
                sb.release_flag, sb.request_latch, sb.owned,
                sa.release_flag, sa.request_latch, sa.owned};

  dppc_top #(.HOLD_CYCLES(200)) i_dppc_top (
    .ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(waitreq), .port_a_pins(pa), .port_b_pins(pb),
    .unit_number_switches(3'h5), .selected_sector_clock(sclk),
    .heads_settled(hset), .offset_done(odone), .track_end_strobe(tes),
    .port_a_stat(sa), .port_b_stat(sb), .drive_out(dout),
    .bad_address(bad), .cylinder_ready(crdy));
  dppc_drive_model i_dppc_drive_model (
    .ref_clk(ref_clk), .slow(slow), .drive_out(dout),
    .selected_sector_clock(sclk), .heads_settled(hset),
    .offset_done(odone));

  task summarize;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      summarize;
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // One Avalon access; waits for waitrequest low, no fixed latency
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50) chk("bus answer", 32'h0, 32'h1);
  endtask
  task rchk(input string n, input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, e, rd & 32'h1ff);
  endtask
  task waitm(input int b, input logic v);
    int n;
    n = 0;
    while (mon[b] !== v && n < 400) begin
      @(negedge ref_clk);
      n++;
    end
    chk($sformatf("mon bit %0d", b), {31'h0, v}, {31'h0, mon[b]});
  endtask
  task idle;
    int n;
    n = 0;
    do begin
      bus(1'b0, 5'h10, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 100);
  endtask
  task pollcyl(input logic [8:0] v);
    int n;
    n = 0;
    do begin
      bus(1'b0, 5'h0c, 32'h0);
      n++;
    end while (rd[8:0] !== v && n < 100);
    chk("current cylinder", {23'h0, v}, {23'h0, rd[8:0]});
  endtask

  initial begin
    {avs_read, avs_write, dem_a, wr_a, dem_b, wr_b, slow, tes, cs_a} = '0;
    avs_address = '0;
    avs_writedata = '0;
    unit_a = 3'h2;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    @(negedge ref_clk);
    chk("drive out", 32'h0, {22'h0, dout});
    chk("ports", 32'h0, {26'h0, sa, sb});
    bus(1'b1, 5'h0c, 32'h55);
    rchk("ccyl read only", 5'h0c, 32'h0);
    rchk("unmapped", 5'h18, 32'h0);
    @(posedge ref_clk);
    dem_a <= 1'b1;
    repeat (40) @(negedge ref_clk);
    chk("wrong unit", 32'h0, {31'h0, sa.owned});
    @(posedge ref_clk);
    unit_a <= 3'h5;
    waitm(0, 1'b1);
    repeat (40) @(negedge ref_clk);
    chk("read latch", 32'h0, {31'h0, sa.request_latch});
    @(posedge ref_clk);
    dem_a <= 1'b0;
    waitm(0, 1'b0);
    // Joint demand: the next rising handshake clock wins
    for (i = 0; i < 2; i++) begin
      while (hs !== (i ? 4'hc : 4'h4)) @(negedge ref_clk);
      @(posedge ref_clk);
      dem_a <= 1'b1;
      dem_b <= 1'b1;
      waitm(i * 3, 1'b1);
      chk("loser", 32'h0, {31'h0, mon[3 - i * 3]});
      @(posedge ref_clk);
      dem_a <= 1'b0;
      dem_b <= 1'b0;
      waitm(i * 3, 1'b0);
    end
    @(posedge ref_clk);
    {dem_a, wr_a} <= 2'b11;
    waitm(1, 1'b1);
    @(posedge ref_clk);
    {dem_a, wr_a, dem_b, wr_b} <= 4'b0011;
    waitm(4, 1'b1);
    chk("b blocked", 32'h1, {31'h0, mon[0] & ~mon[3]});
    @(posedge ref_clk);
    {dem_b, wr_b} <= 2'b00;
    bus(1'b1, 5'h00, 32'h0b);
    waitm(2, 1'b1);
    waitm(3, 1'b1);
    chk("a latch", 32'h0, {31'h0, mon[1]});
    waitm(3, 1'b0);
    for (i = 0; i < 5; i++) begin
      bus(1'b1, 5'h04, {23'h0, tdc[i]});
      bus(1'b1, 5'h08, {19'h0, tst[i]});
      bus(1'b1, 5'h14, {31'h0, tfx[i][1]});
      bus(1'b1, 5'h00, 32'h05);
      idle;
      chk("bad address", {31'h0, tfx[i][0]}, {31'h0, rd[2]});
      chk("attention", 32'h1, {31'h0, rd[1]});
      chk("bad pin", {31'h0, tfx[i][0]}, {31'h0, mon[9]});
      bus(1'b1, 5'h10, 32'h06);
    end
    slow <= 1'b1;
    bus(1'b1, 5'h04, 32'h5);
    bus(1'b1, 5'h00, 32'h05);
    idle;
    chk("seek done", 32'h2, {30'h0, rd[1:0]});
    rchk("seek ccyl", 5'h0c, 32'h5);
    chk("cylinder ready", 32'h1, {31'h0, mon[8]});
    slow <= 1'b0;
    for (i = 0; i < 2; i++) begin
      bus(1'b1, 5'h00, 32'h0d);
      idle;
      chk("offset on", 32'h3, {30'h0, mon[7:6]});
    end
    bus(1'b1, 5'h04, 32'h7);
    bus(1'b1, 5'h00, 32'h05);
    idle;
    chk("offset off", 32'h0, {30'h0, mon[7:6]});
    rchk("seek ccyl", 5'h0c, 32'h7);
    bus(1'b1, 5'h00, 32'h0d);
    idle;
    bus(1'b1, 5'h10, 32'h02);
    bus(1'b1, 5'h00, 32'h0f);
    idle;
    chk("centred", 32'h2, {28'h0, mon[7:6], rd[1:0]});
    // Control access latches; third handshake phase clears attention
    @(posedge ref_clk);
    {dem_a, cs_a} <= 2'b11;
    waitm(1, 1'b1);
    repeat (24) @(negedge ref_clk);
    rchk("attn pin clear", 5'h10, 32'ha0);
    {dem_a, cs_a} <= 2'b00;
    waitm(0, 1'b0);
    bus(1'b1, 5'h10, 32'h02);
    bus(1'b1, 5'h04, 32'h9);
    bus(1'b1, 5'h00, 32'h19);
    pollcyl(9'h9);
    rchk("implied seek", 5'h10, 32'h1);
    bus(1'b1, 5'h00, 32'h0);
    bus(1'b1, 5'h00, 32'h39);
    @(posedge ref_clk);
    tes <= 1'b1;
    @(posedge ref_clk);
    tes <= 1'b0;
    rchk("spiral dcyl", 5'h04, 32'ha);
    pollcyl(9'ha);
    bus(1'b1, 5'h00, 32'h0);
    summarize;
  end
endmodule
`default_nettype wire
